// [common/serec_pkg.sv]
// serec_pkg: constants, register map, row layout and states of the event recorder.
// assumes a 100 MHz system clock and a 32-bit word-addressed register bus.
package serec_pkg;
  localparam int unsigned CLK_HZ = 100000000;
  localparam int unsigned POWER_HZ = 60; // nominal power-system frequency
  localparam int unsigned EVAL_PER_CYCLE = 8; // evaluations per power cycle
  localparam int unsigned EVAL_CYC = CLK_HZ / (POWER_HZ * EVAL_PER_CYCLE);
  localparam int unsigned MS_TIME = 1; // timestamp resolution, ms
  localparam int unsigned MS_CYC = CLK_HZ / 1000 * MS_TIME;
  localparam int unsigned MS_PER_DAY = 86400000;
  localparam int unsigned LISTS = 3;
  localparam int unsigned LIST_LEN = 24;
  localparam int unsigned SLOTS = LISTS * LIST_LEN; // 72
  localparam int unsigned ROWS = 512;
  localparam int unsigned NCONTACT = 8;
  localparam int unsigned NLED = 8;
  // register word indices
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_CMD = 8'h01;
  localparam logic [7:0] REG_STAT = 8'h02;
  localparam logic [7:0] REG_DATE_NOW = 8'h03;
  localparam logic [7:0] REG_MS_NOW = 8'h04;
  localparam logic [7:0] REG_ARG1 = 8'h05;
  localparam logic [7:0] REG_ARG2 = 8'h06;
  localparam logic [7:0] REG_ROW_STAT = 8'h07;
  localparam logic [7:0] REG_ROW_TIME = 8'h08;
  localparam logic [7:0] REG_ROW_DATE = 8'h09;
  localparam logic [7:0] REG_TERMID = 8'h0a;
  localparam logic [7:0] REG_DEV_ID = 8'h0b;
  localparam logic [7:0] REG_TARGET = 8'h0c;
  localparam logic [7:0] REG_LIST_CNT = 8'h10; // 3 words
  localparam logic [7:0] REG_ALIAS = 8'h14; // 3 words
  localparam logic [7:0] REG_CONTACT = 8'h18; // 8 words
  localparam logic [7:0] REG_LIST = 8'h40; // 72 words
  // command bits
  localparam int unsigned CMD_CLEAR = 0;
  localparam int unsigned CMD_READ_ALL = 1;
  localparam int unsigned CMD_READ_FROM = 2;
  localparam int unsigned CMD_READ_SPAN = 3;
  localparam int unsigned CMD_TARGET_DEF = 4;
  localparam logic [31:0] DEV_ID_VAL = 32'h00c0ffee; // arbitrary value
  localparam logic [15:0] DATE_RST = 16'h0000;

  typedef enum logic [1:0] {SEREC_F_ALL, SEREC_F_FROM, SEREC_F_SPAN} serec_filt_t;
  typedef enum logic [2:0] {SEREC_IDLE, SEREC_REC, SEREC_SCAN_A, SEREC_SCAN_B, SEREC_CLR} serec_st_t;

  // one log row; date packs year[15:9], month[8:5], day[4:0] so it orders chronologically
  typedef struct packed {
    logic [15:0] date;
    logic [26:0] ms;
    logic alias_on;
    logic state;
    logic [6:0] slot;
  } serec_row_t;
endpackage

// [hw/serec_top.sv]
// serec_top: sequential event recorder with avalon-mm register access, output
// contacts and target leds.
// assumes status_in is synchronous to sys_clk_in; software formats reports.
//
// Summary of operation
// - three lists of 24, 72 slots total
// - every list behaves exactly alike
// - sample all slots eight times a power cycle
// - any change either way writes one row, except changes seen while a clear runs
// - keep latest 512 rows in storage
// - row 1 oldest, highest row newest
// - read without date returns all, ascending
// - one date returns rows on/after it
// - two dates return inclusive span
// - date arguments follow date format setting
// - clear command erases every stored row
// - header fields terminal id, time, id
// - row holds date, time, element, state
// - timestamp is change moment within 1ms; the code stamps the ms count of the evaluation tick after the change
// - alias replaces element name when set
// - rising is asserted, falling deasserted
// - output contact bits allowed in lists
// - contacts close or open per form
// - remap bottom leds to chosen row
//
// The Avalon-MM register port and the address map were left to the implementer.
`timescale 1ns/1ps
module serec_top
  import serec_pkg::*;
#(
  parameter int unsigned STATUS_W = 256,
  parameter int unsigned EVAL_CYCLES = EVAL_CYC,
  parameter int unsigned MS_CYCLES = MS_CYC
) (
  input wire logic sys_clk_in, // system clock
  input wire logic resetn_in, // async reset, active low
  input wire logic [7:0] avs_address_in, // word address
  input wire logic avs_read_in, // read request
  input wire logic avs_write_in, // write request
  input wire logic [31:0] avs_writedata_in, // write data
  output logic [31:0] avs_readdata_out, // read data
  output logic avs_waitrequest_out, // low for one answer cycle
  input wire logic [STATUS_W-1:0] status_in, // internal status bits
  input wire logic [NLED-1:0] led_default_in, // default target levels
  input wire logic target_reset_in, // front-panel target reset
  output logic [NCONTACT-1:0] contact_out, // contact closed when high
  output logic [NLED-1:0] led_out // bottom target row
);
  localparam int unsigned IW = $clog2(STATUS_W);

  ////////////////////////////////////////////////////////////////////////////
  // state

  serec_st_t st_q;
  logic wait_q;
  logic [31:0] rdata_q;
  logic date_fmt_q; // 0 month first, 1 year first
  logic [15:0] date_q;
  logic [26:0] ms_q;
  logic [$clog2(MS_CYCLES)-1:0] ms_div_q;
  logic [$clog2(EVAL_CYCLES)-1:0] ev_div_q;
  logic [31:0] termid_q;
  logic [15:0] arg1_q, arg2_q;
  serec_filt_t filt_q;
  logic [4:0] list_cnt_q [LISTS];
  logic [LIST_LEN-1:0] alias_q [LISTS];
  logic [IW-1:0] sel_q [SLOTS];
  logic [IW-1:0] con_sel_q [NCONTACT];
  logic [NCONTACT-1:0] con_nc_q;
  logic [4:0] tgt_row_q;
  logic tgt_on_q;
  logic [SLOTS-1:0] cur, prev_q, chg_q, newv_q;
  logic [15:0] ts_date_q;
  logic [26:0] ts_ms_q;
  logic rec_pend_q;
  logic clr_req_q;
  logic [6:0] slot_q;
  logic [8:0] wr_ptr_q;
  logic [9:0] count_q;
  logic [9:0] cursor_q;
  logic [8:0] clr_ptr_q;
  serec_row_t mem [ROWS];
  serec_row_t rd_row_q;
  serec_row_t hit_row_q;
  logic hit_valid_q;
  logic [9:0] hit_num_q;

  ////////////////////////////////////////////////////////////////////////////
  // bus decode

  logic acc_go, wr_go, tick, ms_tick;
  logic [15:0] lo_date, hi_date;
  logic [8:0] oldest, scan_addr;
  logic match;

  assign acc_go = (avs_read_in | avs_write_in) & wait_q & (st_q == SEREC_IDLE) & ~rec_pend_q & ~clr_req_q;
  assign wr_go = acc_go & avs_write_in;
  assign tick = (ev_div_q == '0);
  assign ms_tick = (ms_div_q == '0);

  // argument dates in the user's order are turned into storage order
  function automatic logic [15:0] to_store(input logic [15:0] a, input logic year_first_order);
    to_store = year_first_order ? a : {a[6:0], a[15:12], a[11:7]};
  endfunction

  assign lo_date = to_store(arg1_q, date_fmt_q);
  assign hi_date = to_store(arg2_q, date_fmt_q);
  assign oldest = wr_ptr_q - count_q[8:0]; // wraps naturally over 512 rows
  assign scan_addr = oldest + cursor_q[8:0];

  // filter on the fetched row
  always_comb begin
    unique case (filt_q)
      SEREC_F_ALL: match = 1'b1;
      SEREC_F_FROM: match = (rd_row_q.date >= lo_date);
      SEREC_F_SPAN: match = (rd_row_q.date >= lo_date) && (rd_row_q.date <= hi_date);
      default: match = 1'b0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // per-slot sampling: the list a slot sits in makes no difference

  for (genvar k = 0; k < SLOTS; k++) begin : g_slot
    localparam int unsigned L = k / LIST_LEN;
    localparam int unsigned E = k % LIST_LEN;
    // any status bit is legal here, contact outputs included
    assign cur[k] = (5'(E) < list_cnt_q[L]) & status_in[sel_q[k]];
  end

  ////////////////////////////////////////////////////////////////////////////
  // time base: ms counter within day, evaluation divider

  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      ms_div_q <= '0;
      ms_q <= '0;
      date_q <= DATE_RST;
    end else begin
      ms_div_q <= ms_tick ? ($clog2(MS_CYCLES))'(MS_CYCLES - 1) : ms_div_q - 1'b1;
      if (wr_go && avs_address_in == REG_MS_NOW) begin
        ms_q <= avs_writedata_in[26:0];
      end else if (ms_tick) begin
        // midnight wraps the ms count; software advances the date
        ms_q <= (ms_q == 27'(MS_PER_DAY - 1)) ? '0 : ms_q + 1'b1;
      end
      if (wr_go && avs_address_in == REG_DATE_NOW) begin
        date_q <= avs_writedata_in[15:0];
      end
    end
  end

  // evaluation tick, change capture with timestamp of the tick
  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      ev_div_q <= '0;
      prev_q <= '0;
      chg_q <= '0;
      newv_q <= '0;
      ts_date_q <= '0;
      ts_ms_q <= '0;
      rec_pend_q <= 1'b0;
    end else begin
      ev_div_q <= tick ? ($clog2(EVAL_CYCLES))'(EVAL_CYCLES - 1) : ev_div_q - 1'b1;
      if (tick) begin
        prev_q <= cur;
        // changes seen while erasing are dropped, not logged into a half-cleared store
        if (st_q != SEREC_CLR && !clr_req_q) begin
          chg_q <= cur ^ prev_q;
          newv_q <= cur;
          ts_date_q <= date_q;
          ts_ms_q <= ms_q;
          rec_pend_q <= |(cur ^ prev_q);
        end
      end else if (st_q == SEREC_REC && slot_q == 7'(SLOTS - 1)) begin
        rec_pend_q <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // configuration registers

  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      date_fmt_q <= 1'b0;
      termid_q <= '0;
      arg1_q <= '0;
      arg2_q <= '0;
      con_nc_q <= '0;
      tgt_on_q <= 1'b0;
      tgt_row_q <= '0;
      for (int i = 0; i < LISTS; i++) begin
        list_cnt_q[i] <= '0;
        alias_q[i] <= '0;
      end
      for (int i = 0; i < SLOTS; i++) begin
        sel_q[i] <= '0;
      end
      for (int i = 0; i < NCONTACT; i++) begin
        con_sel_q[i] <= '0;
      end
    end else begin
      if (target_reset_in) begin
        tgt_on_q <= 1'b0;
      end
      if (wr_go) begin
        if (avs_address_in == REG_CTRL) date_fmt_q <= avs_writedata_in[0];
        if (avs_address_in == REG_TERMID) termid_q <= avs_writedata_in;
        if (avs_address_in == REG_ARG1) arg1_q <= avs_writedata_in[15:0];
        if (avs_address_in == REG_ARG2) arg2_q <= avs_writedata_in[15:0];
        if (avs_address_in == REG_TARGET) begin
          tgt_row_q <= avs_writedata_in[4:0];
          tgt_on_q <= 1'b1;
        end
        if (avs_address_in == REG_CMD && avs_writedata_in[CMD_TARGET_DEF]) tgt_on_q <= 1'b0;
        for (int i = 0; i < LISTS; i++) begin
          if (avs_address_in == REG_LIST_CNT + 8'(i)) begin
            list_cnt_q[i] <= (avs_writedata_in > 32'(LIST_LEN)) ? 5'(LIST_LEN) : avs_writedata_in[4:0];
          end
          if (avs_address_in == REG_ALIAS + 8'(i)) alias_q[i] <= avs_writedata_in[LIST_LEN-1:0];
        end
        for (int i = 0; i < SLOTS; i++) begin
          if (avs_address_in == REG_LIST + 8'(i)) sel_q[i] <= avs_writedata_in[IW-1:0];
        end
        for (int i = 0; i < NCONTACT; i++) begin
          if (avs_address_in == REG_CONTACT + 8'(i)) begin
            con_sel_q[i] <= avs_writedata_in[IW-1:0];
            con_nc_q[i] <= avs_writedata_in[8];
          end
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // log store: recording, clearing and filtered read-back

  // row storage; only one writer is active per state
  always_ff @(posedge sys_clk_in) begin
    if (st_q == SEREC_REC && chg_q[slot_q]) begin
      mem[wr_ptr_q] <= '{date: ts_date_q, ms: ts_ms_q, alias_on: alias_q[slot_q / LIST_LEN][slot_q % LIST_LEN],
                         state: newv_q[slot_q], slot: slot_q};
    end else if (st_q == SEREC_CLR) begin
      mem[clr_ptr_q] <= '0;
    end
    rd_row_q <= mem[scan_addr];
  end

  // main sequencer and bus answers
  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      st_q <= SEREC_IDLE;
      wait_q <= 1'b1;
      rdata_q <= '0;
      clr_req_q <= 1'b0;
      slot_q <= '0;
      wr_ptr_q <= '0;
      count_q <= '0;
      cursor_q <= '0;
      clr_ptr_q <= '0;
      filt_q <= SEREC_F_ALL;
      hit_row_q <= '0;
      hit_valid_q <= 1'b0;
      hit_num_q <= '0;
    end else begin
      wait_q <= 1'b1;
      unique case (st_q)
        SEREC_IDLE: begin
          if (clr_req_q) begin
            clr_req_q <= 1'b0;
            clr_ptr_q <= '0;
            st_q <= SEREC_CLR;
          end else if (rec_pend_q) begin
            slot_q <= '0;
            st_q <= SEREC_REC;
          end else if (acc_go && avs_read_in && avs_address_in == REG_ROW_STAT) begin
            st_q <= SEREC_SCAN_A; // answer held back until a row is found or the rows run out
          end else if (acc_go) begin
            wait_q <= 1'b0;
            rdata_q <= '0;
            if (avs_write_in && avs_address_in == REG_CMD) begin
              if (avs_writedata_in[CMD_CLEAR]) clr_req_q <= 1'b1;
              if (avs_writedata_in[CMD_READ_ALL]) begin
                filt_q <= SEREC_F_ALL;
                cursor_q <= '0;
              end
              if (avs_writedata_in[CMD_READ_FROM]) begin
                filt_q <= SEREC_F_FROM;
                cursor_q <= '0;
              end
              if (avs_writedata_in[CMD_READ_SPAN]) begin
                filt_q <= SEREC_F_SPAN;
                cursor_q <= '0;
              end
            end
            if (avs_read_in) begin
              unique case (avs_address_in)
                REG_CTRL: rdata_q <= {31'h0, date_fmt_q};
                REG_STAT: rdata_q <= {21'h0, clr_req_q, count_q};
                REG_DATE_NOW: rdata_q <= {16'h0, date_q};
                REG_MS_NOW: rdata_q <= {5'h0, ms_q};
                REG_ARG1: rdata_q <= {16'h0, arg1_q};
                REG_ARG2: rdata_q <= {16'h0, arg2_q};
                REG_ROW_TIME: rdata_q <= {5'h0, hit_row_q.ms};
                REG_ROW_DATE: rdata_q <= {16'h0, hit_row_q.date};
                REG_TERMID: rdata_q <= termid_q;
                REG_DEV_ID: rdata_q <= DEV_ID_VAL;
                REG_TARGET: rdata_q <= {26'h0, tgt_on_q, tgt_row_q};
                default: begin
                  for (int i = 0; i < LISTS; i++) begin
                    if (avs_address_in == REG_LIST_CNT + 8'(i)) rdata_q <= {27'h0, list_cnt_q[i]};
                    if (avs_address_in == REG_ALIAS + 8'(i)) rdata_q <= 32'(alias_q[i]);
                  end
                  for (int i = 0; i < SLOTS; i++) begin
                    if (avs_address_in == REG_LIST + 8'(i)) rdata_q <= 32'(sel_q[i]);
                  end
                  for (int i = 0; i < NCONTACT; i++) begin
                    if (avs_address_in == REG_CONTACT + 8'(i)) rdata_q <= {23'h0, con_nc_q[i], 8'(con_sel_q[i])};
                  end
                end
              endcase
            end
          end
        end
        SEREC_REC: begin
          if (chg_q[slot_q]) begin
            wr_ptr_q <= wr_ptr_q + 1'b1;
            // full store: write pointer overruns the oldest row, count stays
            if (count_q != 10'(ROWS)) count_q <= count_q + 1'b1;
          end
          slot_q <= slot_q + 1'b1;
          if (slot_q == 7'(SLOTS - 1)) st_q <= SEREC_IDLE;
        end
        SEREC_SCAN_A: begin
          // memory read of scan_addr lands in rd_row_q next cycle
          if (cursor_q >= count_q) begin
            hit_valid_q <= 1'b0;
            rdata_q <= '0;
            wait_q <= 1'b0;
            st_q <= SEREC_IDLE;
          end else begin
            st_q <= SEREC_SCAN_B;
          end
        end
        SEREC_SCAN_B: begin
          cursor_q <= cursor_q + 1'b1;
          if (match) begin
            hit_row_q <= rd_row_q;
            hit_valid_q <= 1'b1;
            hit_num_q <= cursor_q + 1'b1;
            rdata_q <= {1'b1, 11'h0, rd_row_q.alias_on, rd_row_q.state, 1'b0, rd_row_q.slot, cursor_q + 1'b1};
            wait_q <= 1'b0;
            st_q <= SEREC_IDLE;
          end else begin
            st_q <= SEREC_SCAN_A;
          end
        end
        SEREC_CLR: begin
          clr_ptr_q <= clr_ptr_q + 1'b1;
          if (clr_ptr_q == 9'(ROWS - 1)) begin
            count_q <= '0;
            wr_ptr_q <= '0;
            cursor_q <= '0;
            hit_valid_q <= 1'b0;
            st_q <= SEREC_IDLE;
          end
        end
        default: st_q <= SEREC_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // contacts and target leds

  // a normally-closed contact is simply the inverted condition
  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      contact_out <= '0;
    end else begin
      for (int i = 0; i < NCONTACT; i++) begin
        contact_out[i] <= status_in[con_sel_q[i]] ^ con_nc_q[i];
      end
    end
  end

  // remapped leds follow pickup and dropout of the chosen status row
  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      led_out <= '0;
    end else begin
      led_out <= led_default_in;
      for (int i = 0; i < NLED; i++) begin
        // the button takes effect on the leds at once, not a cycle after the remap flag drops
        if (tgt_on_q && !target_reset_in && (int'(tgt_row_q) * NLED + i) < STATUS_W) begin
          led_out[i] <= status_in[int'(tgt_row_q) * NLED + i];
        end
      end
    end
  end

  assign avs_waitrequest_out = wait_q;
  assign avs_readdata_out = rdata_q;
endmodule

// [testbench/serec_asserts.sv]
// checker for the recorder register port and the target leds
// assumes it is bound onto serec_top and sees only its ports
`timescale 1ns/1ps
module serec_checker
  import serec_pkg::*;
(
  input wire logic sys_clk_in, // system clock
  input wire logic resetn_in, // reset, active low
  input wire logic [7:0] avs_address_in, // word address
  input wire logic avs_read_in, // read request
  input wire logic avs_write_in, // write request
  input wire logic [31:0] avs_readdata_out, // read data
  input wire logic avs_waitrequest_out, // wait
  input wire logic [NLED-1:0] led_default_in, // default leds
  input wire logic target_reset_in, // target reset
  input wire logic [NLED-1:0] led_out // target leds
);
  ////////////////////////////////////////
  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (!resetn_in);

  // handshake: one answer per request, never a stuck or doubled strobe
  a_wait_pulse: assert property (!avs_waitrequest_out |=> avs_waitrequest_out)
    else $error("answer strobe longer than one cycle");
  a_ans_has_req: assert property (!avs_waitrequest_out |-> (avs_read_in || avs_write_in))
    else $error("answer without a request");
  a_no_instant: assert property ($rose(avs_read_in || avs_write_in) |-> avs_waitrequest_out)
    else $error("answer in the request cycle");
  // bound covers a clear plus one record ahead of the request
  a_ans_bounded: assert property ($rose(avs_read_in || avs_write_in) && avs_address_in != REG_ROW_STAT
    |-> ##[1:700] !avs_waitrequest_out)
    else $error("register answer overdue");
  a_rd_hold: assert property (avs_waitrequest_out && $past(avs_waitrequest_out) |-> $stable(avs_readdata_out))
    else $error("read data moved between answers");

  // read contents and target-reset leds
  a_unmapped_zero: assert property (!avs_waitrequest_out && avs_read_in
    && (avs_address_in == 8'h0d || avs_address_in >= 8'h88) |-> avs_readdata_out == 32'h0)
    else $error("unmapped read not zero");
  a_dev_id_val: assert property (
    !avs_waitrequest_out && avs_read_in && avs_address_in == REG_DEV_ID |-> avs_readdata_out == DEV_ID_VAL)
    else $error("identification word wrong");
  a_row_end_zero: assert property (
    !avs_waitrequest_out && avs_read_in && avs_address_in == REG_ROW_STAT && !avs_readdata_out[31]
    |-> avs_readdata_out == 32'h0)
    else $error("end of rows not all zero");
  a_led_default: assert property (target_reset_in |=> led_out == $past(led_default_in))
    else $error("target reset did not restore leds");

  ////////////////////////////////////////
  c_row_valid: cover property (!avs_waitrequest_out && avs_read_in && avs_address_in == REG_ROW_STAT
    && avs_readdata_out[31]);
  c_row_end: cover property (!avs_waitrequest_out && avs_read_in && avs_address_in == REG_ROW_STAT
    && !avs_readdata_out[31]);
  c_tgt_reset: cover property (target_reset_in);
endmodule

bind serec_top serec_checker u_chk (
  .sys_clk_in(sys_clk_in),
  .resetn_in(resetn_in),
  .avs_address_in(avs_address_in),
  .avs_read_in(avs_read_in),
  .avs_write_in(avs_write_in),
  .avs_readdata_out(avs_readdata_out),
  .avs_waitrequest_out(avs_waitrequest_out),
  .led_default_in(led_default_in),
  .target_reset_in(target_reset_in),
  .led_out(led_out)
);

// [testbench/serec_term.sv]
// operator terminal model: issues register commands over avalon-mm
// assumes the slave answers by dropping waitrequest for one cycle
`timescale 1ns/1ps
module serec_term
  import serec_pkg::*;
(
  input wire logic clk_in, // system clock
  input wire logic wait_in, // slave waitrequest
  input wire logic [31:0] rdata_in, // slave read data
  output logic [7:0] addr_out, // word address
  output logic rd_out, // read request
  output logic wr_out, // write request
  output logic [31:0] wdata_out // write data
);
  ////////////////////////////////////////
  // bus idle from time zero
  initial begin
    addr_out = 8'h00;
    rd_out = 1'b0;
    wr_out = 1'b0;
    wdata_out = 32'h0;
  end

  // one transfer, held until waitrequest drops; no wait count is assumed, the bench watchdog ends a hang
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge clk_in);
    addr_out <= a;
    wdata_out <= d;
    rd_out <= !w;
    wr_out <= w;
    do @(posedge clk_in); while (wait_in !== 1'b0);
    q = rdata_in;
    rd_out <= 1'b0;
    wr_out <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    xfer(1'b1, a, d, q);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    xfer(1'b0, a, 32'h0, q);
  endtask

  // clears only on request; storage wear keeps them rare
  task automatic clear_log();
    wr(REG_CMD, 32'h1 << CMD_CLEAR);
  endtask
endmodule

// [testbench/testbench.sv]
// self-checking bench for the event recorder
// assumes serec_term drives the register port and the checker is bound on
`timescale 1ns/1ps
module testbench
  import serec_pkg::*;
;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [255:0] status = '0;
  logic [7:0] led_def = 8'h3c;
  logic tgt_rst = 1'b0;
  logic [7:0] addr;
  logic rd;
  logic wr;
  logic waitreq;
  logic [31:0] wdata;
  logic [31:0] rdata;
  logic [7:0] contact;
  logic [7:0] leds;
  logic [31:0] q;
  logic [31:0] t;
  logic [31:0] exp_row [$];
  logic [6:0] sl [3] = '{7'h00, 7'h18, 7'h47};
  int n_mismatch = 0;
  int tests_run = 0;

  ////////////////////////////////////////
  always #5 clk = ~clk;

  // short tick and ms counts keep the wrap test near 40k cycles
  serec_top #(.EVAL_CYCLES(100), .MS_CYCLES(10)) uut (
    .sys_clk_in(clk), .resetn_in(rst_n), .avs_address_in(addr), .avs_read_in(rd),
    .avs_write_in(wr), .avs_writedata_in(wdata), .avs_readdata_out(rdata),
    .avs_waitrequest_out(waitreq), .status_in(status), .led_default_in(led_def),
    .target_reset_in(tgt_rst), .contact_out(contact), .led_out(leds));

  serec_term term (.clk_in(clk), .wait_in(waitreq), .rdata_in(rdata), .addr_out(addr),
    .rd_out(rd), .wr_out(wr), .wdata_out(wdata));

  ////////////////////////////////////////
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
    term.rd(a, q);
    chk(q, e);
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge clk);
  endtask

  function automatic logic [31:0] row(input logic [6:0] s, input logic st, input logic al, input logic [9:0] n);
    return {1'b1, 11'h0, al, st, 1'b0, s, n};
  endfunction

  // issue a read command, walk the rows it yields, then the end marker
  task automatic walk(input int cmd, input int n);
    term.wr(REG_CMD, 32'h1 << cmd);
    for (int i = 0; i < n; i++) begin
      rdchk(REG_ROW_STAT, exp_row[i]);
    end
    rdchk(REG_ROW_STAT, 32'h0);
  endtask

  task automatic stop_test();
    $display("checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  ////////////////////////////////////////
  initial begin
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    rdchk(REG_DEV_ID, DEV_ID_VAL);
    term.wr(8'h0d, 32'h5a5a5a5a);
    rdchk(8'h0d, 32'h0);
    term.wr(REG_TERMID, 32'h1234abcd);
    rdchk(REG_TERMID, 32'h1234abcd);
    // slots 0, 24, 71: heads of lists one and two, tail of list three
    term.wr(REG_LIST_CNT, 32'h1);
    term.wr(REG_LIST_CNT + 8'h1, 32'h1);
    term.wr(REG_LIST_CNT + 8'h2, 32'h1e);
    rdchk(REG_LIST_CNT + 8'h2, 32'h18);
    term.wr(REG_LIST, 32'ha);
    term.wr(REG_LIST + 8'h18, 32'hb);
    term.wr(REG_LIST + 8'h47, 32'hc);
    term.wr(REG_ALIAS + 8'h1, 32'h1);
    term.wr(REG_DATE_NOW, 32'h21);
    rdchk(REG_DATE_NOW, 32'h21);
    // all three rise together, then all fall: six rows in slot order
    status[12:10] <= 3'h7;
    idle(300);
    status[12:10] <= 3'h0;
    idle(300);
    rdchk(REG_STAT, 32'h6);
    for (int i = 0; i < 6; i++) exp_row.push_back(row(sl[i % 3], i < 3, i % 3 == 1, 10'(i + 1)));
    walk(CMD_READ_ALL, 6);
    term.wr(REG_CMD, 32'h1 << CMD_READ_ALL);
    term.rd(REG_ROW_STAT, q);
    rdchk(REG_ROW_DATE, 32'h21);
    // first row's ms stamp lies shortly before the running ms count
    term.rd(REG_ROW_TIME, t);
    term.rd(REG_MS_NOW, q);
    chk(32'(q > t && q - t < 32'd200), 32'h1);
    // year-first arguments, matching and missing the stored date
    term.wr(REG_CTRL, 32'h1);
    term.wr(REG_ARG1, 32'h21);
    walk(CMD_READ_FROM, 6);
    term.wr(REG_ARG2, 32'h21);
    walk(CMD_READ_SPAN, 6);
    term.wr(REG_ARG2, 32'h20);
    walk(CMD_READ_SPAN, 0);
    term.wr(REG_ARG1, 32'h22);
    walk(CMD_READ_FROM, 0);
    // month-first: 1/1/0 matches, 1/2/0 does not
    term.wr(REG_CTRL, 32'h0);
    term.wr(REG_ARG1, 32'h1080);
    walk(CMD_READ_FROM, 6);
    term.wr(REG_ARG1, 32'h1100);
    walk(CMD_READ_FROM, 0);
    term.clear_log();
    rdchk(REG_STAT, 32'h0);
    walk(CMD_READ_ALL, 0);
    // 528 transitions into 512 rows: the oldest 16 are dropped
    for (int k = 0; k < 176; k++) begin
      status[12:10] <= {3{~k[0]}};
      idle(230);
    end
    rdchk(REG_STAT, 32'h200);
    term.wr(REG_CMD, 32'h1 << CMD_READ_ALL);
    rdchk(REG_ROW_STAT, row(7'h18, 1'b0, 1'b1, 10'h1));
    // contact zero on status bit 5, make form then break form
    term.wr(REG_CONTACT, 32'h5);
    status[5] <= 1'b1;
    idle(3);
    chk(32'(contact[0]), 32'h1);
    term.wr(REG_CONTACT, 32'h105);
    idle(3);
    chk(32'(contact[0]), 32'h0);
    // remap to status row 2, back to defaults by button and by command
    term.wr(REG_TARGET, 32'h2);
    rdchk(REG_TARGET, 32'h22);
    status[23:16] <= 8'ha5;
    idle(3);
    chk(32'(leds), 32'ha5);
    tgt_rst <= 1'b1;
    idle(2);
    tgt_rst <= 1'b0;
    chk(32'(leds), 32'h3c);
    term.wr(REG_TARGET, 32'h2);
    term.wr(REG_CMD, 32'h1 << CMD_TARGET_DEF);
    idle(3);
    chk(32'(leds), 32'h3c);
    stop_test();
  end

  // watchdog sized at about twice the expected run
  initial begin
    repeat (80000) @(posedge clk);
    n_mismatch++;
    $display("BAD %0t watchdog expired", $time);
    stop_test();
  end
endmodule
